// File: design/vout_limit_defines.vh
// Command codes, field layout, reset values and timing for the limit block
`ifndef VOUT_LIMIT_DEFINES_VH
`define VOUT_LIMIT_DEFINES_VH

// Command codes of the four registers
`define CODE_UPPER_LIMIT   8'h24
`define CODE_MARGIN_HIGH   8'h25
`define CODE_MARGIN_LOW    8'h26
`define CODE_SLEW_RATE     8'h27

// Slew-rate register fields
`define SLEW_EXP_MSB       15
`define SLEW_EXP_LSB       11
`define SLEW_MAN_MSB       10
`define SLEW_MAN_LSB       0
`define SLEW_EXP_RESET     5'h1c

// Margin field of the operation command
`define MARGIN_OFF         2'h0
`define MARGIN_LOW         2'h1
`define MARGIN_HIGH        2'h2

// Rate span in 1/1024 mV/us: 0.067 and 15.933 mV/us
`define RATE_Q10_SHIFT     10
`define RATE_Q10_MIN       32'h00000045
`define RATE_Q10_MAX       32'h00003fbb
// Ramp rate grid is 1/16 mV/us, so Q10 to grid is a shift of 6
`define RATE_GRID_SHIFT    6
`define RATE_GRID_HALF     32'h00000020

// Ramp tick: one microsecond at a 10 ns clock
`define SLEW_TICK_NS       1000
`define CLK_PERIOD_NS      10
`define SLEW_TICK_CYCLES   (`SLEW_TICK_NS / `CLK_PERIOD_NS)

`endif

// File: design/sticky_flag.v
// One status flag: set by hardware, cleared by the host, set wins
`timescale 1ns/1ps
module sticky_flag (
	// Clock and reset
	input  wire sys_clk,
	input  wire reset_n,
	// Control
	input  wire set,
	input  wire clear,
	// State
	output reg  flag
);

	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			flag <= 1'b0;
		end else if (set) begin
			flag <= 1'b1;
		end else if (clear) begin
			flag <= 1'b0;
		end
	end

endmodule

// File: design/slew_ramp.v
// Reference ramp that walks toward the target at a fixed step per tick
`timescale 1ns/1ps
`include "vout_limit_defines.vh"
module slew_ramp #(
	parameter WIDTH      = 16,
	parameter FRAC       = 4,
	parameter TICK_COUNT = `SLEW_TICK_CYCLES
) (
	// Clock and reset
	input  wire             sys_clk,
	input  wire             reset_n,
	// Control
	input  wire             bypass,
	input  wire [WIDTH-1:0] target,
	input  wire [7:0]       step,
	// Result
	output wire [WIDTH-1:0] level,
	output wire             settled
);

	localparam AW = WIDTH + FRAC;

	reg  [15:0]   tickCount;
	reg           tick;
	reg  [AW-1:0] acc;
	wire [AW-1:0] goal = {target, {FRAC{1'b0}}};
	wire [AW-1:0] stepW = {{(AW-8){1'b0}}, step};
	wire [AW-1:0] gap = (acc < goal) ? goal - acc : acc - goal;

	// Divider gives a one-cycle enable each microsecond
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			tickCount <= 16'h0000;
			tick      <= 1'b0;
		end else if (tickCount == TICK_COUNT - 1) begin
			tickCount <= 16'h0000;
			tick      <= 1'b1;
		end else begin
			tickCount <= tickCount + 16'h0001;
			tick      <= 1'b0;
		end
	end

	// Last step lands exactly on the goal, never past it
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			acc <= {AW{1'b0}};
		end else if (bypass) begin
			acc <= goal;
		end else if (tick && acc != goal) begin
			if (gap <= stepW)
				acc <= goal;
			else if (acc < goal)
				acc <= acc + stepW;
			else
				acc <= acc - stepW;
		end
	end

	assign level   = acc[AW-1:FRAC];
	assign settled = (acc == goal);

endmodule

// File: design/vout_limit_margin_slew_regs.v
// Upper limit, margin targets, slew rate, target clamp and warning status
//
// Function
// - While converting, a new target above the upper limit raises the clamp warning.
// - An over-limit target is replaced by the upper limit and reached at the slew rate.
// - The clamp warning sets the catch-all, word VOUT and min/max warning status bits.
// - The clamp warning also pulls the host alert line.
// - Writing an upper limit below the present target gives the same clamp response.
// - The upper limit is a 16-bit read/write unsigned absolute value.
// - Margin high selects margin-high value plus trim as the target.
// - Margin low selects margin-low value plus trim as the target.
// - Target moves on entering or leaving margin follow the slew rate.
// - Margin-high plus trim above the upper limit is clamped and warned.
// - Invalid margin or slew-rate writes are rejected, flagged and alerted.
// - The slew rate governs normal changes but not turn-on or turn-off ramps.
// - Slew rate is a 5-bit exponent resetting to -4 over an 11-bit mantissa.
// - Any valid slew code reads back as written; the ramp uses the nearest rate.
// - A target below the lower limit is clamped to it with the same warning.
`timescale 1ns/1ps
`include "vout_limit_defines.vh"
module vout_limit_margin_slew_regs #(
	parameter WIDTH      = 16,
	parameter FRAC       = 4,
	parameter TICK_COUNT = `SLEW_TICK_CYCLES
) (
	// Clock and reset
	input  wire             sys_clk,
	input  wire             reset_n,
	// Command port
	input  wire             cmdStrobe,
	input  wire             cmdWrite,
	input  wire [7:0]       cmdCode,
	input  wire [15:0]      cmdWrData,
	output reg  [15:0]      cmdRdData,
	output reg              cmdRdValid,
	output reg              cmdHit,
	// Values restored from non-volatile memory at reset release
	input  wire [15:0]      nvmUpperLimit,
	input  wire [15:0]      nvmMarginHigh,
	input  wire [15:0]      nvmMarginLow,
	input  wire [10:0]      nvmSlewMantissa,
	// Other converter settings
	input  wire [15:0]      setpoint,
	input  wire [15:0]      offsetTrim,
	input  wire [15:0]      lowerLimit,
	input  wire [15:0]      marginValidMax,
	input  wire [1:0]       marginSelect,
	input  wire             converting,
	input  wire             startStopRamp,
	// Status clear from the fault-clear command
	input  wire             clearStatus,
	// Reference outputs
	output reg  [15:0]      refTarget,
	output wire [15:0]      refLevel,
	output wire             refSettled,
	// Status
	output wire             statusOtherFlag,
	output wire             statusWordVout,
	output wire             statusMaxMinWarn,
	output wire             statusInvalidData,
	output reg              alert_n
);

	// Register file
	reg  [15:0] output_upper_limit;
	reg  [15:0] margin_high_target;
	reg  [15:0] margin_low_target;
	reg  [15:0] setpoint_slew_rate;
	reg         bootLoad;

	// Ramp rate on the 1/16 mV/us grid
	reg  [7:0]  slewStep;

	// Target evaluation
	reg  [16:0] baseWide;
	reg  [17:0] sumWide;
	reg  [15:0] next_refTarget;
	reg         overUpper;
	reg         underLower;
	reg  [17:0] prevSum;
	reg  [15:0] prevUpper;
	reg  [15:0] prevLower;
	reg         evalValid;
	reg         clampWarn;
	reg         invalidWrite;

	wire [4:0]  slew_rate_exponent =
		setpoint_slew_rate[`SLEW_EXP_MSB:`SLEW_EXP_LSB];
	wire [10:0] slew_rate_mantissa =
		setpoint_slew_rate[`SLEW_MAN_MSB:`SLEW_MAN_LSB];
	wire [15:0] margin_high_value = margin_high_target;
	wire [15:0] margin_low_value  = margin_low_target;

	wire wrStrobe = cmdStrobe && cmdWrite;
	wire rdStrobe = cmdStrobe && !cmdWrite;

	// Rate in 1/1024 mV/us; oversize results saturate
	function [31:0] rateQ10;
		input [15:0] code;
		reg signed [5:0]  sh;
		reg        [31:0] mag;
		begin
			sh  = $signed({code[15], code[15:11]}) + 6'sh0a;
			mag = {{21{1'b0}}, code[10:0]};
			if (code[10])
				rateQ10 = 32'h00000000;
			else if (sh > 6'sh0e)
				// Saturate below bit 31 so the rounding add cannot wrap
				rateQ10 = 32'h7fffffff;
			else if (sh >= 6'sh00)
				rateQ10 = mag << sh;
			else
				rateQ10 = mag >> (-sh);
		end
	endfunction

	function rateValid;
		input [15:0] code;
		reg [31:0] q;
		begin
			q = rateQ10(code);
			rateValid = (q >= `RATE_Q10_MIN) && (q <= `RATE_Q10_MAX);
		end
	endfunction

	// Nearest supported grid rate, never zero
	function [7:0] rateStep;
		input [15:0] code;
		reg [31:0] g;
		begin
			g = (rateQ10(code) + `RATE_GRID_HALF) >> `RATE_GRID_SHIFT;
			if (g == 32'h00000000)
				rateStep = 8'h01;
			else if (g > 32'h000000ff)
				rateStep = 8'hff;
			else
				rateStep = g[7:0];
		end
	endfunction

	// Margin value plus signed trim, checked against the data span
	function marginValid;
		input [15:0] value;
		input [15:0] trim;
		input [15:0] span;
		reg [17:0] s;
		begin
			s = {2'b00, value} + {{2{trim[15]}}, trim};
			marginValid = !s[17] && (s <= {2'b00, span});
		end
	endfunction

	// Register writes and the post-reset restore
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			output_upper_limit <= 16'h0000;
			margin_high_target <= 16'h0000;
			margin_low_target  <= 16'h0000;
			setpoint_slew_rate <= {`SLEW_EXP_RESET, 11'h000};
			bootLoad           <= 1'b1;
			invalidWrite       <= 1'b0;
		end else if (bootLoad) begin
			// Restore happens one edge after release, not under reset
			output_upper_limit <= nvmUpperLimit;
			margin_high_target <= nvmMarginHigh;
			margin_low_target  <= nvmMarginLow;
			setpoint_slew_rate <= {`SLEW_EXP_RESET, nvmSlewMantissa};
			bootLoad           <= 1'b0;
			invalidWrite       <= 1'b0;
		end else begin
			invalidWrite <= 1'b0;
			if (wrStrobe) begin
				case (cmdCode)
				`CODE_UPPER_LIMIT: begin
					output_upper_limit <= cmdWrData;
				end
				`CODE_MARGIN_HIGH: begin
					if (marginValid(cmdWrData, offsetTrim, marginValidMax))
						margin_high_target <= cmdWrData;
					else
						invalidWrite <= 1'b1;
				end
				`CODE_MARGIN_LOW: begin
					if (marginValid(cmdWrData, offsetTrim, marginValidMax))
						margin_low_target <= cmdWrData;
					else
						invalidWrite <= 1'b1;
				end
				`CODE_SLEW_RATE: begin
					if (rateValid(cmdWrData))
						setpoint_slew_rate <= cmdWrData;
					else
						invalidWrite <= 1'b1;
				end
				default: begin
				end
				endcase
			end
		end
	end

	// Stored code reads back untouched; the ramp sees the rounded rate
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			slewStep <= 8'h01;
		else
			slewStep <= rateStep(setpoint_slew_rate);
	end

	// Read path: answer one cycle after the strobe
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cmdRdData  <= 16'h0000;
			cmdRdValid <= 1'b0;
			cmdHit     <= 1'b0;
		end else begin
			cmdRdValid <= rdStrobe;
			cmdHit     <= cmdStrobe &&
				(cmdCode == `CODE_UPPER_LIMIT ||
				 cmdCode == `CODE_MARGIN_HIGH ||
				 cmdCode == `CODE_MARGIN_LOW  ||
				 cmdCode == `CODE_SLEW_RATE);
			if (rdStrobe) begin
				case (cmdCode)
				`CODE_UPPER_LIMIT: cmdRdData <= output_upper_limit;
				`CODE_MARGIN_HIGH: cmdRdData <= margin_high_value;
				`CODE_MARGIN_LOW:  cmdRdData <= margin_low_value;
				`CODE_SLEW_RATE:   cmdRdData <= {slew_rate_exponent,
					slew_rate_mantissa};
				default:           cmdRdData <= 16'h0000;
				endcase
			end
		end
	end

	// Effective target: selected base plus trim, then clamped
	always @* begin
		case (marginSelect)
		`MARGIN_HIGH: baseWide = {1'b0, margin_high_value};
		`MARGIN_LOW:  baseWide = {1'b0, margin_low_value};
		default:      baseWide = {1'b0, setpoint};
		endcase
		sumWide    = {1'b0, baseWide} + {{2{offsetTrim[15]}}, offsetTrim};
		overUpper  = !sumWide[17] &&
			(sumWide > {2'b00, output_upper_limit});
		underLower = sumWide[17] ||
			(sumWide < {2'b00, lowerLimit});
		if (overUpper)
			next_refTarget = output_upper_limit;
		else if (underLower)
			next_refTarget = lowerLimit;
		else
			next_refTarget = sumWide[15:0];
	end

	// Any change of a contributor or a limit is re-checked
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			prevSum   <= 18'h00000;
			prevUpper <= 16'h0000;
			prevLower <= 16'h0000;
			evalValid <= 1'b0;
			clampWarn <= 1'b0;
			refTarget <= 16'h0000;
		end else begin
			prevSum   <= sumWide;
			prevUpper <= output_upper_limit;
			prevLower <= lowerLimit;
			evalValid <= !bootLoad;
			refTarget <= next_refTarget;
			// One warning per change; a steady violation is not re-flagged
			clampWarn <= evalValid && !bootLoad && converting &&
				(overUpper || underLower) &&
				(sumWide != prevSum ||
				 output_upper_limit != prevUpper ||
				 lowerLimit != prevLower);
		end
	end

	// Slew applies in conversion; start and stop ramps bypass it
	slew_ramp #(
		.WIDTH      (WIDTH),
		.FRAC       (FRAC),
		.TICK_COUNT (TICK_COUNT)
	) u_ramp (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.bypass  (startStopRamp || !converting),
		.target  (refTarget),
		.step    (slewStep),
		.level   (refLevel),
		.settled (refSettled)
	);

	// Status bits: catch-all, word VOUT, min/max warning, bad data
	sticky_flag u_other (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.set     (clampWarn || invalidWrite),
		.clear   (clearStatus),
		.flag    (statusOtherFlag)
	);

	sticky_flag u_word_vout (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.set     (clampWarn),
		.clear   (clearStatus),
		.flag    (statusWordVout)
	);

	sticky_flag u_max_min (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.set     (clampWarn),
		.clear   (clearStatus),
		.flag    (statusMaxMinWarn)
	);

	sticky_flag u_invalid (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.set     (invalidWrite),
		.clear   (clearStatus),
		.flag    (statusInvalidData)
	);

	// Alert stays low while any warning is pending
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			alert_n <= 1'b1;
		else
			alert_n <= !(statusMaxMinWarn || statusInvalidData ||
				clampWarn || invalidWrite);
	end

endmodule

// File: verification/vout_limit_assertions.sv
// Port checks for the limit, margin and slew block
`timescale 1ns/1ps
module vout_limit_assertions (
	// Clock and reset
	input wire        sys_clk,
	input wire        reset_n,
	// Command port
	input wire        cmdStrobe,
	input wire        cmdWrite,
	input wire [7:0]  cmdCode,
	input wire [15:0] cmdWrData,
	input wire        cmdRdValid,
	input wire        cmdHit,
	// Settings
	input wire [15:0] lowerLimit,
	input wire        converting,
	input wire        startStopRamp,
	input wire        clearStatus,
	// Reference and status
	input wire [15:0] refTarget,
	input wire [15:0] refLevel,
	input wire        refSettled,
	input wire        statusOtherFlag,
	input wire        statusWordVout,
	input wire        statusMaxMinWarn,
	input wire        statusInvalidData,
	input wire        alert_n
);
	// Restore edges never warn, so clamp checks wait for them
	reg  [1:0] armCnt;
	wire       armed = armCnt == 2'h3;
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			armCnt <= 2'h0;
		else if (!armed)
			armCnt <= armCnt + 2'h1;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence s_warn;
		statusMaxMinWarn && statusWordVout && statusOtherFlag && !alert_n;
	endsequence
	sequence s_bad;
		statusInvalidData && statusOtherFlag && !alert_n;
	endsequence
	sequence s_badRate;
		cmdStrobe && cmdWrite && cmdCode == 8'h27 && cmdWrData[15:11] == 5'h1c
			&& (cmdWrData[10:0] < 11'h002 || cmdWrData[10:0] > 11'h0fe);
	endsequence
	sequence s_cleared;
		clearStatus && statusMaxMinWarn ##1 !statusMaxMinWarn
			&& !statusInvalidData;
	endsequence
	a_read_answer: assert property (
		cmdStrobe && !cmdWrite |=> cmdRdValid)
		else $error("read strobe got no read valid");
	a_code_hit: assert property (
		cmdStrobe && cmdCode[7:2] == 6'h09 |=> cmdHit)
		else $error("known code got no hit");
	a_idle_quiet: assert property (!cmdStrobe |=> !cmdHit && !cmdRdValid)
		else $error("answer without a strobe");
	a_rate_reject: assert property (s_badRate |-> ##[1:3] s_bad)
		else $error("bad slew rate not flagged");
	a_lower_clamp: assert property (
		armed && converting && $changed(lowerLimit) && lowerLimit > refTarget
		|=> refTarget == $past(lowerLimit) ##1 s_warn)
		else $error("target not clamped to lower limit");
	a_warn_set: assert property ($rose(statusMaxMinWarn) |-> s_warn)
		else $error("warning without all its status and alert");
	a_bypass_follow: assert property (
		armed && startStopRamp |=> refLevel == $past(refTarget))
		else $error("start or stop ramp did not bypass slew");
	a_settled_match: assert property (
		refSettled |-> refLevel == refTarget)
		else $error("settled while level differs from target");
	// Largest step is 255/16 of a target LSB, so one cycle moves 16 at most
	a_slew_bound: assert property (
		$past(converting && !startStopRamp) |->
		(refLevel >= $past(refLevel) ? refLevel - $past(refLevel)
			: $past(refLevel) - refLevel) <= 16'h0010)
		else $error("reference moved faster than the slew step allows");
	a_alert_release: assert property (s_cleared |=> alert_n)
		else $error("alert held after status clear");
endmodule

bind vout_limit_margin_slew_regs vout_limit_assertions
	vout_limit_assertions_i (
	.sys_clk(sys_clk), .reset_n(reset_n), .cmdStrobe(cmdStrobe),
	.cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdWrData(cmdWrData),
	.cmdRdValid(cmdRdValid), .cmdHit(cmdHit), .lowerLimit(lowerLimit),
	.converting(converting), .startStopRamp(startStopRamp),
	.clearStatus(clearStatus), .refTarget(refTarget), .refLevel(refLevel),
	.refSettled(refSettled), .statusOtherFlag(statusOtherFlag),
	.statusWordVout(statusWordVout), .statusMaxMinWarn(statusMaxMinWarn),
	.statusInvalidData(statusInvalidData), .alert_n(alert_n));

// File: verification/host_model.sv
// Host model that issues word commands
`timescale 1ns/1ps
module host_model (
	// Clock
	input  wire        sys_clk,
	// Command port
	output reg         cmdStrobe,
	output reg         cmdWrite,
	output reg  [7:0]  cmdCode,
	output reg  [15:0] cmdWrData,
	input  wire [15:0] cmdRdData,
	input  wire        cmdHit
);
	initial begin
		cmdStrobe = 1'b0;
		cmdWrite = 1'b0;
		cmdCode = 8'h00;
		cmdWrData = 16'h0000;
	end
	// Idle lines show inverted junk so stale values are never trusted
	task xfer(input wr, input [7:0] code, input [15:0] data,
		output [15:0] rd, output hit);
		begin
			@(negedge sys_clk);
			cmdStrobe = 1'b1;
			cmdWrite = wr;
			cmdCode = code;
			cmdWrData = data;
			@(negedge sys_clk);
			cmdStrobe = 1'b0;
			cmdWrite = ~wr;
			cmdCode = ~code;
			cmdWrData = ~data;
			rd = cmdRdData;
			hit = cmdHit;
		end
	endtask
endmodule

// File: verification/tb.sv
// Bench for the limit, margin and slew block
`timescale 1ns/1ps
module tb;
	reg         sys_clk = 1'b0;
	reg         reset_n = 1'b0;
	reg         converting = 1'b1;
	reg         startStopRamp = 1'b1;
	reg         clearStatus = 1'b0;
	reg  [1:0]  marginSelect = 2'h0;
	reg  [15:0] setpoint = 16'h0400;
	reg  [15:0] offsetTrim = 16'h0000;
	reg  [15:0] lowerLimit = 16'h0100;
	reg  [15:0] rv [0:3];
	reg  [10:0] tbl [0:4];
	reg  [15:0] rd;
	reg         hit;
	reg  [10:0] m;
	integer     i, n, errorCnt = 0, numChecks = 0;
	wire        cmdStrobe, cmdWrite, cmdRdValid, cmdHit, refSettled, alert_n;
	wire        statusOtherFlag, statusWordVout, statusMaxMinWarn;
	wire        statusInvalidData;
	wire [7:0]  cmdCode;
	wire [15:0] cmdWrData, cmdRdData, refTarget, refLevel;
	initial begin
		rv[0] = 16'h0800;
		rv[1] = 16'h0500;
		rv[2] = 16'h0300;
		rv[3] = 16'he020;
		tbl[0] = 11'h001;
		tbl[1] = 11'h002;
		tbl[2] = 11'h0fe;
		tbl[3] = 11'h0ff;
		tbl[4] = 11'h7ff;
	end
	always #5 sys_clk = ~sys_clk;
	vout_limit_margin_slew_regs #(.TICK_COUNT(4))
		vout_limit_margin_slew_regs_i (
		.sys_clk(sys_clk), .reset_n(reset_n), .cmdStrobe(cmdStrobe),
		.cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdWrData(cmdWrData),
		.cmdRdData(cmdRdData), .cmdRdValid(cmdRdValid), .cmdHit(cmdHit),
		.nvmUpperLimit(rv[0]), .nvmMarginHigh(rv[1]), .nvmMarginLow(rv[2]),
		.nvmSlewMantissa(rv[3][10:0]), .setpoint(setpoint),
		.offsetTrim(offsetTrim), .lowerLimit(lowerLimit),
		.marginValidMax(16'h0700), .marginSelect(marginSelect),
		.converting(converting), .startStopRamp(startStopRamp),
		.clearStatus(clearStatus), .refTarget(refTarget),
		.refLevel(refLevel), .refSettled(refSettled),
		.statusOtherFlag(statusOtherFlag), .statusWordVout(statusWordVout),
		.statusMaxMinWarn(statusMaxMinWarn),
		.statusInvalidData(statusInvalidData), .alert_n(alert_n));
	host_model host_model_i (.sys_clk(sys_clk), .cmdStrobe(cmdStrobe),
		.cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdWrData(cmdWrData),
		.cmdRdData(cmdRdData), .cmdHit(cmdHit));
	function [15:0] eff(input [1:0] sel);
		reg [16:0] s;
		begin
			s = (sel == 2'h2 ? rv[1] : sel == 2'h1 ? rv[2] : setpoint)
				+ offsetTrim;
			eff = s > rv[0] ? rv[0] : s < lowerLimit ? lowerLimit : s[15:0];
		end
	endfunction
	function okRate(input [10:0] mm);
		okRate = !mm[10] && mm * 64 >= 69 && mm * 64 <= 16315;
	endfunction
	task stopTest;
		begin
			if (errorCnt == 0 && numChecks > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	task chk(input [15:0] got, input [15:0] exp);
		begin
			numChecks = numChecks + 1;
			if (got !== exp) begin
				$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
				errorCnt = errorCnt + 1;
			end
		end
	endtask
	task cyc(input integer k);
		repeat (k) @(negedge sys_clk);
	endtask
	task rw(input wr, input [7:0] c, input [15:0] d);
		host_model_i.xfer(wr, c, d, rd, hit);
	endtask
	task flags(input [3:0] e);
		chk({11'h0, statusOtherFlag, statusWordVout, statusMaxMinWarn,
			statusInvalidData, alert_n}, {11'h0, e, ~(e[1] | e[0])});
	endtask
	task clr;
		begin
			clearStatus = 1'b1;
			cyc(1);
			clearStatus = 1'b0;
			cyc(2);
			flags(4'h0);
		end
	endtask
	// Bounded wait; a hang counts as a mismatch
	task settle;
		begin
			cyc(2);
			n = 0;
			while (refSettled !== 1'b1 && n < 20000) begin
				cyc(1);
				n = n + 1;
			end
			if (n == 20000) begin
				errorCnt = errorCnt + 1;
				stopTest;
			end
		end
	endtask
	initial begin
		void'($urandom(54384));
		cyc(4);
		reset_n = 1'b1;
		cyc(3);
		for (i = 0; i < 4; i = i + 1) begin
			rw(1'b0, 8'h24 + i[7:0], 16'h0000);
			chk(rd, rv[i]);
			chk({15'h0, hit}, 16'h0001);
		end
		rw(1'b0, 8'h28, 16'h0000);
		chk(rd | {15'h0, hit}, 16'h0000);
		chk(refLevel, eff(2'h0));
		startStopRamp = 1'b0;
		for (i = 0; i < 8; i = i + 1) begin
			m = i < 5 ? tbl[i] : 11'h002 + $urandom % 253;
			rw(1'b1, 8'h27, {5'h1c, m});
			cyc(3);
			if (okRate(m))
				rv[3] = {5'h1c, m};
			flags({!okRate(m), 2'h0, !okRate(m)});
			rw(1'b0, 8'h27, 16'h0000);
			chk(rd, rv[3]);
			clr;
		end
		rv[3] = 16'he020;
		rw(1'b1, 8'h27, rv[3]);
		settle;
		setpoint = setpoint + 16'h000a;
		settle;
		chk(refLevel, eff(2'h0));
		chk({15'h0, n >= 12 && n <= 24}, 16'h0001);
		offsetTrim = 16'h0010;
		for (i = 0; i < 4; i = i + 1) begin
			marginSelect = i[1:0];
			cyc(3);
			chk(refTarget, eff(marginSelect));
			flags(4'h0);
		end
		for (i = 1; i < 3; i = i + 1) begin
			rw(1'b1, 8'h24 + i[7:0], 16'h06f1);
			cyc(3);
			flags(4'h9);
			clr;
			rv[i] = 16'h0400 + $urandom % 16'h0200;
			rw(1'b1, 8'h24 + i[7:0], rv[i]);
			rw(1'b0, 8'h24 + i[7:0], 16'h0000);
			chk(rd, rv[i]);
		end
		marginSelect = 2'h2;
		cyc(4);
		rv[0] = 16'h0400;
		rw(1'b1, 8'h24, rv[0]);
		cyc(4);
		chk(refTarget, 16'h0400);
		flags(4'he);
		settle;
		chk(refLevel, 16'h0400);
		clr;
		rv[1] = 16'h06e0;
		rw(1'b1, 8'h25, rv[1]);
		cyc(4);
		flags(4'he);
		clr;
		converting = 1'b0;
		rv[1] = 16'h06f0;
		rw(1'b1, 8'h25, rv[1]);
		cyc(4);
		flags(4'h0);
		converting = 1'b1;
		rv[0] = 16'h0800;
		rw(1'b1, 8'h24, rv[0]);
		marginSelect = 2'h0;
		cyc(4);
		clr;
		lowerLimit = setpoint + 16'h0020;
		cyc(3);
		chk(refTarget, eff(2'h0));
		flags(4'he);
		lowerLimit = 16'h0100;
		cyc(4);
		clr;
		for (i = 0; i < 16; i = i + 1) begin
			setpoint = 16'h0200 + $urandom % 16'h0400;
			offsetTrim = $urandom % 16'h0040;
			marginSelect = $urandom % 4;
			cyc(3);
			chk(refTarget, eff(marginSelect));
		end
		stopTest;
	end
endmodule
